// >>> bench/serial_flash_command_interface_bench.sv
// Self-checking bench for the serial flash command interface
module serial_flash_command_interface_bench import sfc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys_in = 1'b0, rst_b_in = 1'b0, eight_sector_in = 1'b0;
    logic       sclk, cs_b, cmd, sdo, oe, wip, wel, rej;
    logic [2:0] prot;
    logic [7:0] rxq[$];
    int         n_fail = 0, n_tests = 0, n_rej = 0, n_oe = 0, cyc = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    sfc_cmd_if dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .serial_clock_in(sclk),
        .serial_chip_select_b_in(cs_b), .serial_command_input_in(cmd), .serial_data_out(sdo),
        .serial_data_oe_out(oe), .eight_sector_in(eight_sector_in), .wip_out(wip), .wel_out(wel),
        .protect_level_out(prot), .op_rejected_out(rej));
    sfc_master_model m_u (.clk_sys_in(clk_sys_in), .serial_clock_out(sclk), .serial_chip_select_b_out(cs_b),
        .serial_command_out(cmd), .serial_data_in(sdo));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(negedge clk_sys_in) begin
        cyc++;
        if (rej === 1'b1) n_rej++;
        if (oe === 1'b1) n_oe++;
        if (cyc == 95000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic frame(input logic [7:0] q[$], input int tail = 8);
        logic [7:0] r;
        rxq = {};
        m_u.start();
        foreach (q[i]) begin
            m_u.xfer(q[i], (i == q.size() - 1) ? tail : 8, r);
            rxq.push_back(r);
        end
        m_u.stop();
    endtask
    task automatic refused(input logic [7:0] q[$], input int tail = 8);
        int r0;
        r0 = n_rej;
        frame(q, tail);
        chk(8'(n_rej - r0), 8'h01, "not refused");
    endtask
    task automatic st(input logic [7:0] exp);
        frame({OP_READ_STATUS, 8'h00, 8'h00});
        chk(rxq[1], exp, "status");
        chk(rxq[2], exp, "status repeat");
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 3000 && wip !== 1'b0; k++) @(negedge clk_sys_in);
        chk(8'(k < 3000), 8'h01, "stuck busy");
    endtask
    task automatic wsr(input logic [7:0] d, input logic [2:0] exp);
        frame({OP_WRITE_ENABLE});
        frame({OP_WRITE_STATUS, d});
        wait_idle();
        chk(prot, exp, "protect");
    endtask
    task automatic t_reset();
        chk({prot, rej, sdo, oe, wel, wip}, 8'h00, "reset");
    endtask
    task automatic t_latch();
        frame({OP_WRITE_ENABLE}, 7);
        chk(wel, 1'b0, "partial enable");
        frame({OP_WRITE_ENABLE});
        chk(wel, 1'b1, "enable");
        st(8'h02);
        frame({OP_WRITE_DISABLE});
        chk(wel, 1'b0, "disable");
    endtask
    task automatic t_page();
        logic [7:0] q[$];
        int o0;
        frame({OP_WRITE_ENABLE});
        frame({OP_BULK_ERASE});
        chk(wip, 1'b1, "bulk busy");
        st(8'h03);
        o0 = n_oe;
        frame({OP_READ_BYTES, 8'h00, 8'h02, 8'h00, 8'h00});
        chk(8'(n_oe - o0), 8'h00, "read while busy");
        wait_idle();
        chk(wel, 1'b0, "latch after erase");
        refused({OP_WRITE_BYTES, 8'h00, 8'h02, 8'h00, 8'h0F});
        frame({OP_WRITE_ENABLE});
        refused({OP_WRITE_BYTES, 8'h00, 8'h02, 8'h00, 8'h0F}, 4);
        q = {OP_WRITE_BYTES, 8'h00, 8'h02, 8'h00, 8'h0F};
        repeat (255) q.push_back(8'h77);
        q.push_back(8'hF0);
        frame(q);
        chk(wip, 1'b1, "page busy");
        wait_idle();
        o0 = n_oe;
        frame({OP_READ_BYTES, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00});
        chk(8'(n_oe > o0), 8'h01, "read drives output");
        chk(rxq[4], 8'hF0, "page wrap");
        chk(rxq[5], 8'h77, "stream");
        frame({OP_FAST_READ, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00});
        chk(rxq[5], ERASED_BYTE, "fast read");
        chk(rxq[6], 8'hF0, "fast stream");
    endtask
    task automatic t_ids();
        frame({OP_SILICON_ID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(rxq[4], SILICON_ID_VALUE, "silicon id");
        chk(rxq[5], SILICON_ID_VALUE, "id repeat");
        frame({OP_DEVICE_ID, 8'h00, 8'h00, 8'h00});
        chk(rxq[3], DEVICE_ID_VALUE, "device id");
    endtask
    task automatic t_protect();
        wsr(8'hE7, 3'h1);
        st(8'h04);
        frame({OP_WRITE_ENABLE});
        refused({OP_SECTOR_ERASE, 8'h00, 8'h06, 8'h00});
        refused({OP_BULK_ERASE});
        frame({OP_SECTOR_ERASE, 8'h00, 8'h04, 8'h00});
        chk(wip, 1'b1, "open sector");
        wait_idle();
        eight_sector_in = 1'b1;
        wsr(8'h08, 3'h2);
        frame({OP_WRITE_ENABLE});
        refused({OP_SECTOR_ERASE, 8'h00, 8'h06, 8'h00});
        frame({OP_SECTOR_ERASE, 8'h00, 8'h05, 8'h00});
        chk(wip, 1'b1, "open sector eight");
        wait_idle();
    endtask
    initial begin
        repeat (2) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        repeat (6) @(negedge clk_sys_in);
        t_reset();
        t_latch();
        t_page();
        t_ids();
        t_protect();
        summarize();
    end
endmodule // serial_flash_command_interface_bench

// >>> bench/sfc_checker.sv
// Port assertions for the serial flash command interface
module sfc_checker (
    // Clock and reset
    input wire logic       clk_sys_in,
    input wire logic       rst_b_in,
    // Serial link pins
    input wire logic       serial_clock_in,
    input wire logic       serial_chip_select_b_in,
    input wire logic       serial_command_input_in,
    input wire logic       serial_data_out,
    input wire logic       serial_data_oe_out,
    // Configuration and status
    input wire logic       eight_sector_in,
    input wire logic       wip_out,
    input wire logic       wel_out,
    input wire logic [2:0] protect_level_out,
    input wire logic       op_rejected_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    logic [11:0] busy_q;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) busy_q <= 12'h000;
        else busy_q <= wip_out ? busy_q + 12'h001 : 12'h000;
    end
    out_idle_a:
        assert property (serial_chip_select_b_in [*8] |-> !serial_data_oe_out && !serial_data_out)
        else $error("output driven while deselected");
    fall_update_a:
        assert property ($changed(serial_data_out) |-> !serial_clock_in) else $error("data changed while clock high");
    oe_select_a:
        assert property ($rose(serial_data_oe_out) |-> !serial_chip_select_b_in) else $error("oe rose deselected");
    wel_set_a:
        assert property ($rose(wel_out) |-> serial_chip_select_b_in) else $error("latch set inside frame");
    wip_start_a:
        assert property ($rose(wip_out) |-> $past(wel_out) && serial_chip_select_b_in) else $error("cycle without latch");
    wel_clear_a:
        assert property ($fell(wip_out) |-> !wel_out) else $error("latch kept after cycle");
    busy_min_a:
        assert property ($rose(wip_out) |-> wip_out [*8]) else $error("busy too short");
    busy_max_a:
        assert property (busy_q < 12'h900) else $error("busy too long");
    reject_pulse_a:
        assert property (op_rejected_out |-> serial_chip_select_b_in ##1 !op_rejected_out) else $error("bad reject pulse");
    prot_change_a:
        assert property ($changed(protect_level_out) |-> serial_chip_select_b_in && $past(wel_out))
        else $error("protect changed without write");
    four_mode_a:
        assert property (!eight_sector_in |-> !protect_level_out[2]) else $error("bit2 set in four mode");
endmodule // sfc_checker

bind sfc_cmd_if sfc_checker chk_u (.clk_sys_in, .rst_b_in, .serial_clock_in, .serial_chip_select_b_in,
    .serial_command_input_in, .serial_data_out, .serial_data_oe_out, .eight_sector_in, .wip_out, .wel_out,
    .protect_level_out, .op_rejected_out);

// >>> bench/sfc_master_model.sv
// Serial link master model: clock low outside frames, command line toggled when deselected
module sfc_master_model #(
    parameter int HALF_CLKS = 8
) (
    // Clock
    input  wire logic clk_sys_in,
    // Serial link pins
    output logic      serial_clock_out,
    output logic      serial_chip_select_b_out,
    output logic      serial_command_out,
    input  wire logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        serial_clock_out = 1'b0;
        serial_chip_select_b_out = 1'b1;
        serial_command_out = 1'b0;
    end
    task automatic half();
        repeat (HALF_CLKS) @(negedge clk_sys_in);
    endtask
    task automatic start();
        serial_chip_select_b_out = 1'b0;
        half();
    endtask
    // Shift the top nb bits out and the reply in
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            serial_command_out = tx[i];
            half();
            serial_clock_out = 1'b1;
            rx = {rx[6:0], serial_data_in};
            half();
            serial_clock_out = 1'b0;
        end
    endtask
    task automatic stop();
        half();
        serial_chip_select_b_out = 1'b1;
        serial_command_out = ~serial_command_out;
        half();
        half();
    endtask
endmodule // sfc_master_model

// >>> shared/sfc_pkg.sv
// Constants and types for the serial flash command interface
package sfc_pkg;

    // Operation codes
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS   = 8'h05;
    localparam logic [7:0] OP_READ_BYTES    = 8'h03;
    localparam logic [7:0] OP_FAST_READ     = 8'h0B;
    localparam logic [7:0] OP_SILICON_ID    = 8'hAB;
    localparam logic [7:0] OP_DEVICE_ID     = 8'h9F;
    localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
    localparam logic [7:0] OP_WRITE_BYTES   = 8'h02;
    localparam logic [7:0] OP_BULK_ERASE    = 8'hC7;
    localparam logic [7:0] OP_SECTOR_ERASE  = 8'hD8;

    // Identification values, arbitrary
    localparam logic [7:0] SILICON_ID_VALUE = 8'h5A;
    localparam logic [7:0] DEVICE_ID_VALUE  = 8'hA5;

    // Frame lengths in bytes, opcode included
    localparam logic [9:0] HDR_STATUS       = 10'h001;
    localparam logic [9:0] HDR_READ         = 10'h004;
    localparam logic [9:0] HDR_FAST         = 10'h005;
    localparam logic [9:0] HDR_SILICON_ID   = 10'h004;
    localparam logic [9:0] HDR_DEVICE_ID    = 10'h003;
    localparam logic [9:0] LEN_SINGLE       = 10'h001;
    localparam logic [9:0] LEN_WRITE_STATUS = 10'h002;
    localparam logic [9:0] LEN_SECTOR_ERASE = 10'h004;
    localparam logic [9:0] LEN_WRITE_MIN    = 10'h005;
    localparam logic [9:0] BYTE_CNT_MAX     = 10'h3FF;
    localparam logic [9:0] ADDR_BYTE_FIRST  = 10'h001;
    localparam logic [9:0] ADDR_BYTE_LAST   = 10'h003;
    localparam logic [2:0] BIT_LAST         = 3'h7;

    // Array geometry
    localparam int         MEM_AW           = 11;
    localparam int         MEM_DEPTH        = 2048;
    localparam int         PAGE_DEPTH       = 256;
    localparam logic [11:0] MEM_BYTES       = 12'h800;
    localparam logic [11:0] PAGE_BYTES      = 12'h100;
    localparam logic [11:0] SECT4_BYTES     = 12'h200;
    localparam logic [11:0] SECT8_BYTES     = 12'h100;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

    // Protection thresholds, lowest protected sector
    localparam logic [2:0] PROT_LO_TOP1     = 3'h3;
    localparam logic [2:0] PROT_LO_TOP2     = 3'h2;
    localparam logic [2:0] PROT_LO_8_TOP1   = 3'h7;
    localparam logic [2:0] PROT_LO_8_TOP2   = 3'h6;
    localparam logic [2:0] PROT_LO_8_TOP4   = 3'h4;
    localparam logic [2:0] PROT_LO_ALL      = 3'h0;

    // Busy time of a status write
    localparam logic [11:0] STATUS_WRITE_CYCLES = 12'h010;
    localparam logic [11:0] ENG_CNT_LAST        = 12'h001;

    // Pin synchroniser lanes
    localparam int         PIN_CS           = 0;
    localparam int         PIN_SCLK         = 1;
    localparam int         PIN_DIN          = 2;
    localparam int         PIN_EIGHT        = 3;
    localparam logic [3:0] SYNC_RST         = 4'h1;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_OPCODE = 4'b0010,
        ST_BODY   = 4'b0100,
        ST_STREAM = 4'b1000
    } sfc_state_t;

    typedef enum logic [3:0] {
        EN_IDLE   = 4'b0001,
        EN_PROG   = 4'b0010,
        EN_ERASE  = 4'b0100,
        EN_WSTAT  = 4'b1000
    } sfc_engine_t;

    // Status register layout
    typedef struct packed {
        logic [2:0] zero;
        logic [2:0] protect;
        logic       wel;
        logic       wip;
    } sfc_status_t;

    localparam sfc_status_t STATUS_RST = '{zero: 3'h0, protect: 3'h0, wel: 1'b0, wip: 1'b0};

endpackage

// >>> src/sfc_cmd_if.sv
// Serial flash command interface: command decoder, status register, page buffer and array
module sfc_cmd_if
    import sfc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    // Serial link pins
    input  wire logic       serial_clock_in,
    input  wire logic       serial_chip_select_b_in,
    input  wire logic       serial_command_input_in,
    output logic            serial_data_out,
    output logic            serial_data_oe_out,
    // Configuration
    input  wire logic       eight_sector_in,
    // Status
    output logic            wip_out,
    output logic            wel_out,
    output logic [2:0]      protect_level_out,
    output logic            op_rejected_out
);

    // Pin synchronisers and debounced levels
    logic [3:0]   s1_q;
    logic [3:0]   s2_q;
    logic [3:0]   s3_q;
    logic [3:0]   pin_q;
    logic [3:0]   pin_d;
    logic [3:0]   pin_raw;

    assign pin_raw = {eight_sector_in, serial_command_input_in, serial_clock_in, serial_chip_select_b_in};
    assign pin_d   = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_q  <= SYNC_RST;
            s2_q  <= SYNC_RST;
            s3_q  <= SYNC_RST;
            pin_q <= SYNC_RST;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    logic         cs_hi;
    logic         cs_rise;
    logic         sclk_rise;
    logic         sclk_fall;
    logic         din;
    logic         eight;

    assign cs_hi     = pin_q[PIN_CS];
    assign cs_rise   = pin_d[PIN_CS] & ~pin_q[PIN_CS];
    assign sclk_rise = pin_d[PIN_SCLK] & ~pin_q[PIN_SCLK] & ~cs_hi;
    assign sclk_fall = ~pin_d[PIN_SCLK] & pin_q[PIN_SCLK] & ~cs_hi;
    assign din       = pin_d[PIN_DIN];
    assign eight     = pin_q[PIN_EIGHT];

    // Frame counters and shifter
    sfc_state_t   state_q;
    sfc_state_t   state_d;
    logic [2:0]   bit_cnt_q;
    logic [2:0]   bit_cnt_d;
    logic [9:0]   byte_cnt_q;
    logic [9:0]   byte_cnt_d;
    logic [9:0]   new_cnt;
    logic [7:0]   shift_q;
    logic [7:0]   shift_d;
    logic [7:0]   byte_val;
    logic         byte_done;
    logic [7:0]   opcode_q;
    logic [7:0]   opcode_d;
    logic [7:0]   op_now;

    assign byte_done  = sclk_rise & (bit_cnt_q == BIT_LAST);
    assign byte_val   = {shift_q[6:0], din};
    assign new_cnt    = byte_cnt_q + 10'h001;
    assign op_now     = (byte_cnt_q == 10'h000) ? byte_val : opcode_q;
    assign bit_cnt_d  = cs_hi ? 3'h0 : sclk_rise ? bit_cnt_q + 3'h1 : bit_cnt_q;
    assign byte_cnt_d = cs_hi ? 10'h000 :
                        (byte_done && byte_cnt_q != BYTE_CNT_MAX) ? new_cnt : byte_cnt_q;
    assign shift_d    = cs_hi ? 8'h00 : sclk_rise ? byte_val : shift_q;
    assign opcode_d   = (byte_done && byte_cnt_q == 10'h000) ? byte_val : opcode_q;

    // Address collection, bytes one to three
    logic [23:0]  addr_q;
    logic [23:0]  addr_d;
    logic [23:0]  addr_shift;
    logic [23:0]  addr_base;
    logic         addr_phase;

    assign addr_phase = byte_done && byte_cnt_q >= ADDR_BYTE_FIRST && byte_cnt_q <= ADDR_BYTE_LAST;
    assign addr_shift = {addr_q[15:0], byte_val};
    assign addr_base  = addr_phase ? addr_shift : addr_q;

    // Read decode
    logic         is_mem_read;
    logic         is_read;
    logic [9:0]   hdr_len;
    logic         busy;
    logic         read_ok;
    logic         stream_load;
    logic         mem_load;

    assign is_mem_read = (op_now == OP_READ_BYTES) || (op_now == OP_FAST_READ);
    assign is_read     = is_mem_read || (op_now == OP_READ_STATUS) ||
                         (op_now == OP_SILICON_ID) || (op_now == OP_DEVICE_ID);
    assign hdr_len     = (op_now == OP_READ_STATUS) ? HDR_STATUS :
                         (op_now == OP_READ_BYTES)  ? HDR_READ :
                         (op_now == OP_FAST_READ)   ? HDR_FAST :
                         (op_now == OP_SILICON_ID)  ? HDR_SILICON_ID :
                         HDR_DEVICE_ID;
    assign read_ok     = ~busy || (op_now == OP_READ_STATUS);
    assign stream_load = byte_done && is_read && read_ok && new_cnt >= hdr_len;
    assign mem_load    = stream_load && is_mem_read;
    assign addr_d      = mem_load ? addr_base + 24'h000001 : addr_base;

    // Status register
    sfc_status_t  status_q;
    sfc_status_t  status_d;

    // Array and page buffer
    logic [7:0]   mem [MEM_DEPTH];
    logic [7:0]   pbuf [PAGE_DEPTH];
    logic [255:0] pvalid_q;
    logic [255:0] pvalid_d;
    logic [7:0]   page_off_q;
    logic [7:0]   page_off_d;
    logic         pp_data;
    logic         pp_open;
    logic [MEM_AW-1:0] rd_addr;
    logic [7:0]   out_byte;

    assign rd_addr  = addr_base[MEM_AW-1:0];
    assign out_byte = (op_now == OP_READ_STATUS) ? status_q :
                      (op_now == OP_SILICON_ID)  ? SILICON_ID_VALUE :
                      (op_now == OP_DEVICE_ID)   ? DEVICE_ID_VALUE : mem[rd_addr];
    assign pp_open  = byte_done && byte_cnt_q == 10'h000 && byte_val == OP_WRITE_BYTES && ~busy;
    assign pp_data  = byte_done && opcode_q == OP_WRITE_BYTES && byte_cnt_q > ADDR_BYTE_LAST && ~busy;
    assign page_off_d = (byte_done && byte_cnt_q == ADDR_BYTE_LAST) ? byte_val :
                        pp_data ? page_off_q + 8'h01 : page_off_q;
    assign pvalid_d = pp_open ? '0 :
                      pp_data ? (pvalid_q | (256'h1 << page_off_q)) : pvalid_q;

    // Protection decode
    logic [2:0]   sector;
    logic [2:0]   prot_lo;
    logic         prot_any;
    logic         prot_hit;
    logic [MEM_AW-1:0] sect_base;
    logic [11:0]  sect_len;

    assign sector   = eight ? addr_q[MEM_AW-1:8] : {1'b0, addr_q[MEM_AW-1:9]};
    assign prot_any = eight ? (status_q.protect != 3'h0) : (status_q.protect[1:0] != 2'h0);
    assign prot_lo  = eight ? (status_q.protect[2]            ? PROT_LO_ALL :
                               status_q.protect[1:0] == 2'h1  ? PROT_LO_8_TOP1 :
                               status_q.protect[1:0] == 2'h2  ? PROT_LO_8_TOP2 : PROT_LO_8_TOP4)
                            : (status_q.protect[1:0] == 2'h1  ? PROT_LO_TOP1 :
                               status_q.protect[1:0] == 2'h2  ? PROT_LO_TOP2 : PROT_LO_ALL);
    assign prot_hit = prot_any && sector >= prot_lo;
    assign sect_base = eight ? {addr_q[MEM_AW-1:8], 8'h00} : {addr_q[MEM_AW-1:9], 9'h000};
    assign sect_len  = eight ? SECT8_BYTES : SECT4_BYTES;

    // Execution at deselect
    logic         framed;
    logic         wr_ok;
    logic         go_wren;
    logic         go_wrdi;
    logic         go_wrsr;
    logic         go_pp;
    logic         go_se;
    logic         go_be;
    logic         is_wr_op;
    logic         go_any;

    assign framed   = cs_rise && bit_cnt_q == 3'h0;
    assign wr_ok    = framed && ~busy && status_q.wel;
    assign go_wren  = framed && opcode_q == OP_WRITE_ENABLE && byte_cnt_q == LEN_SINGLE;
    assign go_wrdi  = framed && opcode_q == OP_WRITE_DISABLE && byte_cnt_q == LEN_SINGLE;
    assign go_wrsr  = wr_ok && opcode_q == OP_WRITE_STATUS && byte_cnt_q == LEN_WRITE_STATUS;
    assign go_pp    = wr_ok && opcode_q == OP_WRITE_BYTES && byte_cnt_q >= LEN_WRITE_MIN && ~prot_hit;
    assign go_se    = wr_ok && opcode_q == OP_SECTOR_ERASE && byte_cnt_q == LEN_SECTOR_ERASE && ~prot_hit;
    assign go_be    = wr_ok && opcode_q == OP_BULK_ERASE && byte_cnt_q == LEN_SINGLE && ~prot_any;
    assign is_wr_op = opcode_q == OP_WRITE_STATUS || opcode_q == OP_WRITE_BYTES ||
                      opcode_q == OP_SECTOR_ERASE || opcode_q == OP_BULK_ERASE;
    assign go_any   = go_wrsr | go_pp | go_se | go_be;

    // Write and erase engine
    sfc_engine_t  eng_q;
    sfc_engine_t  eng_d;
    logic [11:0]  eng_cnt_q;
    logic [11:0]  eng_cnt_d;
    logic [MEM_AW-1:0] eng_addr_q;
    logic [MEM_AW-1:0] eng_addr_d;
    logic         eng_done;
    logic         mem_we;
    logic [7:0]   mem_wd;

    assign busy     = eng_q != EN_IDLE;
    assign eng_done = busy && eng_cnt_q == ENG_CNT_LAST;
    assign eng_d    = go_pp   ? EN_PROG :
                      (go_se | go_be) ? EN_ERASE :
                      go_wrsr ? EN_WSTAT :
                      eng_done ? EN_IDLE : eng_q;
    assign eng_cnt_d  = go_pp ? PAGE_BYTES : go_se ? sect_len : go_be ? MEM_BYTES :
                        go_wrsr ? STATUS_WRITE_CYCLES : busy ? eng_cnt_q - 12'h001 : eng_cnt_q;
    assign eng_addr_d = go_pp ? {addr_q[MEM_AW-1:8], 8'h00} : go_se ? sect_base :
                        go_be ? '0 : busy ? eng_addr_q + MEM_AW'(1) : eng_addr_q;
    assign mem_we   = (eng_q == EN_PROG && pvalid_q[eng_addr_q[7:0]]) || eng_q == EN_ERASE;
    assign mem_wd   = (eng_q == EN_ERASE) ? ERASED_BYTE : (pbuf[eng_addr_q[7:0]] & mem[eng_addr_q]);

    // Status next value
    always_comb begin
        status_d     = status_q;
        status_d.wip = eng_d != EN_IDLE;
        if (go_wren) begin
            status_d.wel = 1'b1;
        end else if (go_wrdi || eng_done) begin
            status_d.wel = 1'b0;
        end
        if (go_wrsr) begin
            status_d.protect = {addr_q[4] & eight, addr_q[3:2]};
        end
    end

    // Serial output path
    logic [7:0]   tx_q;
    logic [7:0]   tx_d;
    logic         dout_d;
    logic         doe_d;
    logic         shift_out;

    assign shift_out = sclk_fall && state_q == ST_STREAM;
    assign tx_d   = stream_load ? out_byte : shift_out ? {tx_q[6:0], 1'b0} : tx_q;
    assign dout_d = cs_hi ? 1'b0 : shift_out ? tx_q[7] : serial_data_out;
    assign doe_d  = cs_hi ? 1'b0 : shift_out ? 1'b1 : serial_data_oe_out;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:   if (!pin_d[PIN_CS]) state_d = ST_OPCODE;
            ST_OPCODE: if (byte_done) state_d = stream_load ? ST_STREAM : ST_BODY;
            ST_BODY:   if (stream_load) state_d = ST_STREAM;
            ST_STREAM: state_d = ST_STREAM;
        endcase
        if (cs_hi) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q    <= ST_IDLE;
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 10'h000;
            shift_q    <= 8'h00;
            opcode_q   <= 8'h00;
            addr_q     <= 24'h000000;
        end else begin
            state_q    <= state_d;
            bit_cnt_q  <= bit_cnt_d;
            byte_cnt_q <= byte_cnt_d;
            shift_q    <= shift_d;
            opcode_q   <= opcode_d;
            addr_q     <= addr_d;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_q           <= STATUS_RST;
            eng_q              <= EN_IDLE;
            eng_cnt_q          <= 12'h000;
            eng_addr_q         <= '0;
            pvalid_q           <= '0;
            page_off_q         <= 8'h00;
            op_rejected_out    <= 1'b0;
        end else begin
            status_q           <= status_d;
            eng_q              <= eng_d;
            eng_cnt_q          <= eng_cnt_d;
            eng_addr_q         <= eng_addr_d;
            pvalid_q           <= pvalid_d;
            page_off_q         <= page_off_d;
            op_rejected_out    <= cs_rise && is_wr_op && byte_cnt_q != 10'h000 && !go_any;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_q               <= 8'h00;
            serial_data_out    <= 1'b0;
            serial_data_oe_out <= 1'b0;
        end else begin
            tx_q               <= tx_d;
            serial_data_out    <= dout_d;
            serial_data_oe_out <= doe_d;
        end
    end

    // Array and page buffer storage
    always_ff @(posedge clk_sys_in) begin
        if (mem_we) begin
            mem[eng_addr_q] <= mem_wd;
        end
        if (pp_data) begin
            pbuf[page_off_q] <= byte_val;
        end
    end

    assign wip_out           = status_q.wip;
    assign wel_out           = status_q.wel;
    assign protect_level_out = status_q.protect;

endmodule // sfc_cmd_if
